// ---- rtl/ospt_pin_edge.sv ----
// synchroniser and edge qualifier for the external trigger pin
`timescale 1ns/100ps
module ospt_pin_edge
    import ospt_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic srst_in,
    // pin
    input wire logic ext_trigger_pin_in,
    // to core
    ospt_trig_if.det trg
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;
    logic rise;
    logic fall;
    logic [1:0] fill_ff;

    // two-stage synchroniser, then a history stage for edges
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            meta_ff <= 1'h1;
            sync_ff <= 1'h1;
            prev_ff <= 1'h1;
        end else begin
            meta_ff <= ext_trigger_pin_in;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // fill count: the reset value of the chain must not look like an edge
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            fill_ff <= 2'h0;
        end else if (fill_ff != 2'h3) begin
            fill_ff <= fill_ff + 2'h1;
        end
    end

    // edge terms from synchronised samples only, once the chain is filled
    assign rise = sync_ff & ~prev_ff & (fill_ff == 2'h3);
    assign fall = ~sync_ff & prev_ff & (fill_ff == 2'h3);
    // timer trigger edge follows its own polarity bit unless both_edges selects both edges
    assign trg.pin_trig = trg.both_edges ? (rise | fall) :
        (trg.trig_pol ? rise : fall);
    // interrupt edge uses the interrupt polarity unless both_edges selects both edges
    assign trg.pin_irq = trg.both_edges ? (rise | fall) :
        (trg.irq_pol ? rise : fall);
endmodule

// ---- rtl/ospt_pkg.sv ----
// shared constants and types of the one-shot pulse timer
package ospt_pkg;
    // register indices; byte address is four times the index
    localparam logic [9:0] OSPT_IDX_CTRL = 10'h108;
    localparam logic [9:0] OSPT_IDX_OSCTRL = 10'h109;
    localparam logic [9:0] OSPT_IDX_IOCTRL = 10'h10a;
    localparam logic [9:0] OSPT_IDX_MODE = 10'h10b;
    localparam logic [9:0] OSPT_IDX_PRESC = 10'h10c;
    localparam logic [9:0] OSPT_IDX_SECOND = 10'h10d;
    localparam logic [9:0] OSPT_IDX_PRIMARY = 10'h10e;
    // timer_control_reg fields
    localparam int OSPT_CTRL_START_BIT = 0;
    localparam int OSPT_CTRL_ACTIVE_BIT = 1;
    localparam int OSPT_CTRL_FSTOP_BIT = 2;
    // oneshot_control_reg fields
    localparam int OSPT_OS_START_BIT = 0;
    localparam int OSPT_OS_STOP_BIT = 1;
    localparam int OSPT_OS_ACTIVE_BIT = 2;
    // timer_io_control fields
    localparam int OSPT_IO_LEVEL_BIT = 0;
    localparam int OSPT_IO_SWITCH_BIT = 1;
    localparam int OSPT_IO_PINTRG_BIT = 2;
    localparam int OSPT_IO_POL_BIT = 3;
    localparam logic [7:0] OSPT_IO_RESET = 8'h00;
    // mode register fields
    localparam int OSPT_MODE_LSB = 0;
    localparam int OSPT_SRC_LSB = 4;
    localparam logic [1:0] OSPT_MODE_ONESHOT = 2'h2;
    localparam logic [1:0] OSPT_MODE_WAIT = 2'h3;
    localparam logic [7:0] OSPT_MODE_RESET = 8'h00;
    // count source codes
    localparam logic [1:0] OSPT_SRC_DIV1 = 2'h0;
    localparam logic [1:0] OSPT_SRC_DIV2 = 2'h1;
    localparam logic [1:0] OSPT_SRC_DIV8 = 2'h2;
    localparam logic [1:0] OSPT_SRC_NEIGH = 2'h3;
    // counter reset values
    localparam logic [7:0] OSPT_CNT_RESET = 8'hff;
    // one-shot sequence states
    typedef enum logic [1:0] {
        OS_IDLE,
        OS_ARM,
        OS_WAIT,
        OS_PULSE
    } ospt_state_e;
    // byte address of a register index
    function automatic logic [11:0] ospt_addr(input logic [9:0] idx);
        ospt_addr = {idx, 2'h0};
    endfunction
endpackage

// ---- rtl/ospt_timer.sv ----
// one-shot pulse timer with prescaler, reload counter and register slave
`timescale 1ns/100ps
module ospt_timer
    import ospt_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic srst_in,
    // avalon-mm slave
    input wire logic [11:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // count source and pin interrupt setup from neighbours
    input wire logic neigh_underflow_in,
    input wire logic edge_count_select_in,
    input wire logic interrupt_edge_polarity_in,
    // pins and events
    input wire logic ext_trigger_pin_in,
    input wire logic port_latch_in,
    output logic pulse_out_pin_out,
    output logic timer_irq_out,
    output logic pin_irq_out
);
    ospt_trig_if trg();
    logic [31:0] rdata_ff;
    logic [2:0] div_ff;
    // software registers, reload values and live counts
    logic [7:0] wdat, io_ff, mode_ff;
    logic [7:0] pre_rl_ff, pri_rl_ff, sec_rl_ff;
    logic [7:0] pre_cnt_ff, main_cnt_ff;
    ospt_state_e state_ff, nxt_state;
    // single-bit registers
    logic done_ff, start_ff, stage_ff, count_active_ff, irq_ff, pulse_out_ff;
    // strobes and decode terms
    logic req, wr_fire, src_tick, cnt_tick;
    logic os_start_fire, os_stop_fire, fstop_fire, start_clr_fire;
    logic trigger, kill, underflow, run, os_active, is_wait_mode, pulse_lvl;

    // register address decode for reads and writes
    function automatic logic hit(input logic [11:0] a, input logic [9:0] i);
        hit = (a == ospt_addr(i));
    endfunction

    ospt_pin_edge u_pin (
        .core_clk_in(core_clk_in),
        .srst_in(srst_in),
        .ext_trigger_pin_in(ext_trigger_pin_in),
        .trg(trg.det)
    );

    // edge selections handed to the pin detector
    assign trg.trig_pol = io_ff[OSPT_IO_POL_BIT];
    assign trg.irq_pol = interrupt_edge_polarity_in;
    assign trg.both_edges = edge_count_select_in;
    assign pin_irq_out = trg.pin_irq;

    // one wait cycle per access; write lands when waitrequest is low
    assign req = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = req & ~done_ff;
    assign wr_fire = avs_write_in & done_ff & avs_byteenable_in[0];
    assign wdat = avs_writedata_in[7:0];
    assign avs_readdata_out = rdata_ff;

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            done_ff <= 1'h0;
        end else begin
            done_ff <= req & ~done_ff;
        end
    end

    // read data captured in the wait cycle; unmapped reads give zero
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            rdata_ff <= 32'h0;
        end else if (avs_read_in && !done_ff) begin
            rdata_ff <= 32'h0;
            if (hit(avs_address_in, OSPT_IDX_CTRL)) begin
                rdata_ff[OSPT_CTRL_START_BIT] <= start_ff;
                rdata_ff[OSPT_CTRL_ACTIVE_BIT] <= count_active_ff;
            end else if (hit(avs_address_in, OSPT_IDX_OSCTRL)) begin
                rdata_ff[OSPT_OS_ACTIVE_BIT] <= os_active;
            end else if (hit(avs_address_in, OSPT_IDX_IOCTRL)) begin
                rdata_ff[3:0] <= io_ff[3:0];
            end else if (hit(avs_address_in, OSPT_IDX_MODE)) begin
                rdata_ff[7:0] <= mode_ff;
            end else if (hit(avs_address_in, OSPT_IDX_PRESC)) begin
                rdata_ff[7:0] <= pre_cnt_ff;
            end else if (hit(avs_address_in, OSPT_IDX_SECOND)) begin
                rdata_ff[7:0] <= sec_rl_ff;
            end else if (hit(avs_address_in, OSPT_IDX_PRIMARY)) begin
                rdata_ff[7:0] <= main_cnt_ff;
            end
        end
    end

    // command strobes decoded from register writes
    assign os_start_fire = wr_fire && hit(avs_address_in, OSPT_IDX_OSCTRL)
        && wdat[OSPT_OS_START_BIT];
    assign os_stop_fire = wr_fire && hit(avs_address_in, OSPT_IDX_OSCTRL)
        && wdat[OSPT_OS_STOP_BIT];
    assign fstop_fire = wr_fire && hit(avs_address_in, OSPT_IDX_CTRL)
        && wdat[OSPT_CTRL_FSTOP_BIT];
    assign start_clr_fire = wr_fire && hit(avs_address_in, OSPT_IDX_CTRL)
        && !wdat[OSPT_CTRL_START_BIT];

    // io control and mode registers
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            io_ff <= OSPT_IO_RESET;
            mode_ff <= OSPT_MODE_RESET;
        end else begin
            if (wr_fire && hit(avs_address_in, OSPT_IDX_IOCTRL)) begin
                io_ff <= {4'h0, wdat[3:0]};
            end
            if (wr_fire && hit(avs_address_in, OSPT_IDX_MODE)) begin
                mode_ff <= wdat;
            end
        end
    end

    // count source divider and selection
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            div_ff <= 3'h0;
        end else begin
            div_ff <= div_ff + 3'h1;
        end
    end

    always_comb begin
        unique case (mode_ff[OSPT_SRC_LSB +: 2])
            OSPT_SRC_DIV1: src_tick = 1'h1;
            OSPT_SRC_DIV2: src_tick = div_ff[0];
            OSPT_SRC_DIV8: src_tick = (div_ff == 3'h7);
            OSPT_SRC_NEIGH: src_tick = neigh_underflow_in;
        endcase
    end

    // start bit and count-active flag, two count-source stages apart
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            start_ff <= 1'h0;
            stage_ff <= 1'h0;
            count_active_ff <= 1'h0;
        end else if (fstop_fire) begin
            start_ff <= 1'h0;
            stage_ff <= 1'h0;
            count_active_ff <= 1'h0;
        end else begin
            if (wr_fire && hit(avs_address_in, OSPT_IDX_CTRL)) begin
                start_ff <= wdat[OSPT_CTRL_START_BIT];
            end
            if (src_tick) begin
                stage_ff <= start_ff;
                count_active_ff <= stage_ff;
            end
        end
    end

    // sequence control terms
    assign cnt_tick = src_tick & count_active_ff;
    assign is_wait_mode = (mode_ff[OSPT_MODE_LSB +: 2] == OSPT_MODE_WAIT);
    assign run = (mode_ff[OSPT_MODE_LSB +: 2] == OSPT_MODE_ONESHOT)
        || is_wait_mode;
    assign os_active = (state_ff == OS_WAIT) || (state_ff == OS_PULSE);
    assign trigger = os_start_fire
        || (trg.pin_trig && io_ff[OSPT_IO_PINTRG_BIT]);
    assign kill = os_stop_fire || fstop_fire || start_clr_fire
        || !count_active_ff || !run;
    assign underflow = cnt_tick && (pre_cnt_ff == 8'h0)
        && (main_cnt_ff == 8'h0);

    // next state of the one-shot sequence
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            OS_IDLE: begin
                if (trigger && count_active_ff && run) begin
                    nxt_state = OS_ARM;
                end
            end
            OS_ARM: begin
                if (cnt_tick) begin
                    nxt_state = is_wait_mode ? OS_WAIT : OS_PULSE;
                end
            end
            OS_WAIT: begin
                if (underflow) begin
                    nxt_state = OS_PULSE;
                end
            end
            OS_PULSE: begin
                if (underflow) begin
                    nxt_state = OS_IDLE;
                end
            end
        endcase
        if (kill && state_ff != OS_IDLE) begin
            nxt_state = OS_IDLE;
        end
    end

    // state register; triggers in any busy state are ignored
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            state_ff <= OS_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // reload registers, always written by software
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            pre_rl_ff <= OSPT_CNT_RESET;
            pri_rl_ff <= OSPT_CNT_RESET;
            sec_rl_ff <= OSPT_CNT_RESET;
        end else if (wr_fire) begin
            if (hit(avs_address_in, OSPT_IDX_PRESC)) begin
                pre_rl_ff <= wdat;
            end
            if (hit(avs_address_in, OSPT_IDX_PRIMARY)) begin
                pri_rl_ff <= wdat;
            end
            if (hit(avs_address_in, OSPT_IDX_SECOND)) begin
                sec_rl_ff <= wdat;
            end
        end
    end

    // prescaler and main counter
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            pre_cnt_ff <= OSPT_CNT_RESET;
            main_cnt_ff <= OSPT_CNT_RESET;
        end else if (!count_active_ff) begin
            // stopped: writes land in the counters directly
            if (wr_fire && hit(avs_address_in, OSPT_IDX_PRESC)) begin
                pre_cnt_ff <= wdat;
            end else if (!stage_ff) begin
                pre_cnt_ff <= pre_rl_ff;
            end
            if (wr_fire && hit(avs_address_in, OSPT_IDX_PRIMARY)) begin
                main_cnt_ff <= wdat;
            end else if (!stage_ff) begin
                main_cnt_ff <= pri_rl_ff;
            end
        end else if (kill || state_ff == OS_IDLE) begin
            pre_cnt_ff <= pre_rl_ff;
            main_cnt_ff <= pri_rl_ff;
        end else if (state_ff == OS_ARM) begin
            pre_cnt_ff <= pre_rl_ff;
            main_cnt_ff <= pri_rl_ff;
        end else if (cnt_tick) begin
            if (pre_cnt_ff == 8'h0) begin
                pre_cnt_ff <= pre_rl_ff;
                if (main_cnt_ff != 8'h0) begin
                    main_cnt_ff <= main_cnt_ff - 8'h1;
                end else if (state_ff == OS_WAIT) begin
                    main_cnt_ff <= sec_rl_ff;
                end else begin
                    main_cnt_ff <= pri_rl_ff;
                end
            end else begin
                pre_cnt_ff <= pre_cnt_ff - 8'h1;
            end
        end
    end

    // pulse level: from the edge entering the pulse phase to its underflow
    assign pulse_lvl = (nxt_state == OS_PULSE);

    // output pin and end-of-pulse interrupt
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            pulse_out_ff <= 1'h0;
            irq_ff <= 1'h0;
        end else begin
            irq_ff <= (state_ff == OS_PULSE) && underflow && !kill;
            if (io_ff[OSPT_IO_SWITCH_BIT]) begin
                pulse_out_ff <= port_latch_in;
            end else begin
                pulse_out_ff <= pulse_lvl ^ io_ff[OSPT_IO_LEVEL_BIT];
            end
        end
    end

    assign pulse_out_pin_out = pulse_out_ff;
    assign timer_irq_out = irq_ff;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);

    a_force_stop_now: assert property (fstop_fire |=>
        !count_active_ff && !start_ff && state_ff == OS_IDLE)
        else $error("forced stop did not halt the timer");
    a_arm_to_active: assert property (
        state_ff == OS_ARM && cnt_tick && !kill |=>
        (is_wait_mode ? state_ff == OS_WAIT : state_ff == OS_PULSE))
        else $error("one-shot did not become active after arming");
    a_busy_no_restart: assert property (
        os_active && !cnt_tick && !kill |=>
        $stable(state_ff) && $stable(main_cnt_ff) && $stable(pre_cnt_ff))
        else $error("running one-shot changed without a count tick");
    a_wait_loads_sec: assert property (
        state_ff == OS_WAIT && underflow && !kill |=>
        state_ff == OS_PULSE && main_cnt_ff == $past(sec_rl_ff))
        else $error("secondary value not loaded after the wait");
    a_end_irq_pulse: assert property (
        state_ff == OS_PULSE && underflow && !kill |=>
        timer_irq_out && state_ff == OS_IDLE && !os_active ##1 !timer_irq_out)
        else $error("end of pulse did not give one interrupt");
    a_stop_reloads: assert property (
        os_stop_fire && count_active_ff && os_active |=>
        state_ff == OS_IDLE && main_cnt_ff == $past(pri_rl_ff)
        && pre_cnt_ff == $past(pre_rl_ff))
        else $error("stop command did not reload the counters");
    a_pin_gated: assert property (
        state_ff == OS_IDLE && !os_start_fire
        && !io_ff[OSPT_IO_PINTRG_BIT] |=> state_ff == OS_IDLE)
        else $error("pin started a one-shot while disabled");
    a_need_active: assert property (
        state_ff == OS_IDLE && !count_active_ff |=> state_ff == OS_IDLE)
        else $error("one-shot started without count-active flag");
    a_idle_level: assert property (
        state_ff == OS_IDLE && !io_ff[OSPT_IO_SWITCH_BIT] ##1
        state_ff == OS_IDLE |-> pulse_out_pin_out == $past(io_ff[0]))
        else $error("idle pin level does not follow level bit");
    a_io_upper_zero: assert property (
        avs_read_in && !done_ff && hit(avs_address_in, OSPT_IDX_IOCTRL)
        |=> avs_readdata_out[7:4] == 4'h0)
        else $error("reserved io control bits read nonzero");
endmodule

// ---- rtl/ospt_trig_if.sv ----
// trigger path between the pin edge detector and the timer core
`timescale 1ns/100ps
interface ospt_trig_if;
    logic pin_trig;
    logic pin_irq;
    logic trig_pol;
    logic irq_pol;
    logic both_edges;
    modport det (input trig_pol, input irq_pol, input both_edges,
        output pin_trig, output pin_irq);
    modport core (output trig_pol, output irq_pol, output both_edges,
        input pin_trig, input pin_irq);
endinterface

// ---- verif/ospt_pin_model.sv ----
// trigger source and pulse load model on the timer pins
`timescale 1ns/100ps
module ospt_pin_model (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic srst_in,
    // timer pins
    input wire logic pulse_out_pin_in,
    input wire logic timer_irq_in,
    input wire logic idle_level_in,
    output logic ext_trigger_pin_out,
    // measurements
    output int width_out,
    output int pulses_out,
    output int start_out,
    output logic irq_end_out
);
    int run = 0;
    int cyc = 0;
    initial ext_trigger_pin_out = 1'h0;
    // pin level change, held long enough for the sync chain
    task automatic set_pin(input logic v);
        @(posedge core_clk_in);
        ext_trigger_pin_out <= v;
        repeat (4) @(posedge core_clk_in);
    endtask
    // measure each pulse and note the interrupt at its end
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (srst_in) begin
            run <= 0;
            pulses_out <= 0;
            width_out <= 0;
            start_out <= 0;
            irq_end_out <= 1'h0;
        end else if (pulse_out_pin_in !== idle_level_in) begin
            if (run == 0) start_out <= cyc;
            run <= run + 1;
        end else if (run > 0) begin
            width_out <= run;
            pulses_out <= pulses_out + 1;
            irq_end_out <= timer_irq_in;
            run <= 0;
        end
    end
endmodule

// ---- verif/tb.sv ----
// self-checking testbench of the one-shot pulse timer
`timescale 1ns/100ps
module tb
    import ospt_pkg::*;
;
    logic clk = 1'h0;
    logic srst = 1'h1;
    logic [11:0] addr = 12'h000;
    logic rd = 1'h0;
    logic wr = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic waitreq;
    logic neigh = 1'h0;
    logic [1:0] ncnt = 2'h0;
    logic irq_pol = 1'h1;
    logic both_edges = 1'h0;
    logic latch = 1'h1;
    logic idle_lvl = 1'h0;
    logic pin, pulse, tirq, pirq, irq_end;
    logic [7:0] rv;
    int failures = 0;
    int comparisons = 0;
    int pin_irqs = 0;
    int cyc = 0;
    int width, pulses, start, p0, q0, t0;
    int smul [4] = '{1, 2, 8, 4};
    logic [7:0] pio [6] = '{8'h0c, 8'h0c, 8'h04, 8'h04, 8'h00, 8'h00};
    logic plv [6] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0};
    int pexp [6] = '{1, 0, 0, 1, 0, 0};
    logic [9:0] sidx [3] = '{OSPT_IDX_OSCTRL, OSPT_IDX_CTRL, OSPT_IDX_CTRL};
    logic [7:0] sval [3] = '{8'h02, 8'h00, 8'h04};

    always #4 clk = ~clk;
    // neighbour underflow every fourth cycle, pin irq and cycle counts
    always @(posedge clk) begin
        ncnt <= ncnt + 2'h1;
        neigh <= (ncnt == 2'h3);
        cyc <= cyc + 1;
        if (pirq === 1'h1) pin_irqs <= pin_irqs + 1;
    end

    ospt_timer u_dut (.core_clk_in(clk), .srst_in(srst),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
        .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
        .neigh_underflow_in(neigh), .edge_count_select_in(both_edges),
        .interrupt_edge_polarity_in(irq_pol), .ext_trigger_pin_in(pin),
        .port_latch_in(latch), .pulse_out_pin_out(pulse),
        .timer_irq_out(tirq), .pin_irq_out(pirq));
    ospt_pin_model u_pin (.core_clk_in(clk), .srst_in(srst),
        .pulse_out_pin_in(pulse), .timer_irq_in(tirq),
        .idle_level_in(idle_lvl), .ext_trigger_pin_out(pin),
        .width_out(width), .pulses_out(pulses), .start_out(start),
        .irq_end_out(irq_end));

    task automatic test_done();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chkw(input string what, input int exp, input int got);
        comparisons++;
        if (got != exp) begin
            failures++;
            $display("FAIL %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [9:0] idx,
        input logic [7:0] d);
        @(posedge clk);
        addr <= {idx, 2'h0};
        wdata <= {24'h0, d};
        rd <= ~w;
        wr <= w;
        @(posedge clk);
        while (waitreq !== 1'h0) begin
            @(posedge clk);
        end
        rv = rdata[7:0];
        rd <= 1'h0;
        wr <= 1'h0;
    endtask
    task automatic poll(input logic [9:0] idx, input int b, input logic v);
        int n;
        n = 0;
        rv = {8{~v}};
        while (rv[b] !== v && n < 30) begin
            bus(1'h0, idx, 8'h00);
            n++;
        end
        chk("status flag", v, rv[b]);
    endtask
    task automatic restart(input logic [1:0] src, input logic [1:0] md);
        bus(1'h1, OSPT_IDX_CTRL, 8'h00);
        poll(OSPT_IDX_CTRL, OSPT_CTRL_ACTIVE_BIT, 1'h0);
        bus(1'h1, OSPT_IDX_MODE, {2'h0, src, 2'h0, md});
        bus(1'h1, OSPT_IDX_CTRL, 8'h01);
        poll(OSPT_IDX_CTRL, OSPT_CTRL_ACTIVE_BIT, 1'h1);
    endtask
    // io control write, then let the pin settle before measuring again
    task automatic set_io(input logic [7:0] v);
        bus(1'h1, OSPT_IDX_IOCTRL, v);
        repeat (3) @(posedge clk);
        idle_lvl <= v[OSPT_IO_LEVEL_BIT];
        repeat (3) @(posedge clk);
    endtask
    task automatic shot(input logic [9:0] idx, input logic [7:0] v);
        p0 = pulses;
        t0 = cyc;
        bus(1'h1, idx, v);
    endtask
    task automatic wait_pulse();
        int n;
        n = 0;
        while (pulses == p0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        chkw("pulse count", p0 + 1, pulses);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        test_done();
    end

    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'h0;
        bus(1'h0, OSPT_IDX_IOCTRL, 8'h00);
        chk("io reset", OSPT_IO_RESET, rv);
        bus(1'h1, OSPT_IDX_IOCTRL, 8'hf0);
        bus(1'h0, OSPT_IDX_IOCTRL, 8'h00);
        chk("io upper bits", 8'h00, rv);
        bus(1'h0, 10'h000, 8'h00);
        chk("unmapped read", 8'h00, rv);
        bus(1'h1, OSPT_IDX_PRESC, 8'h01);
        bus(1'h1, OSPT_IDX_PRIMARY, 8'h02);
        bus(1'h0, OSPT_IDX_PRIMARY, 8'h00);
        chk("primary stopped", 8'h02, rv);
        shot(OSPT_IDX_OSCTRL, 8'h01);
        repeat (40) @(posedge clk);
        chkw("trigger while stopped", p0, pulses);
        for (int s = 0; s < 4; s++) begin
            restart(s[1:0], OSPT_MODE_ONESHOT);
            shot(OSPT_IDX_OSCTRL, 8'h01);
            wait_pulse();
            chkw("pulse width", smul[s] * 6, width);
            chk("irq at pulse end", 1'h1, irq_end);
        end
        restart(2'h0, OSPT_MODE_ONESHOT);
        bus(1'h0, OSPT_IDX_PRIMARY, 8'h00);
        chk("primary reloaded", 8'h02, rv);
        both_edges <= 1'h0;
        set_io(8'h0c);
        bus(1'h1, OSPT_IDX_PRESC, 8'h00);
        bus(1'h1, OSPT_IDX_PRIMARY, 8'h3f);
        shot(OSPT_IDX_OSCTRL, 8'h01);
        poll(OSPT_IDX_OSCTRL, OSPT_OS_ACTIVE_BIT, 1'h1);
        bus(1'h0, OSPT_IDX_PRIMARY, 8'h00);
        chk("primary live", 1'h1, rv < 8'h3f);
        bus(1'h1, OSPT_IDX_PRIMARY, 8'h05);
        q0 = pin_irqs;
        u_pin.set_pin(1'h1);
        u_pin.set_pin(1'h0);
        bus(1'h1, OSPT_IDX_OSCTRL, 8'h01);
        wait_pulse();
        chkw("width after retrigger", 64, width);
        chkw("pin irq during pulse", q0 + 1, pin_irqs);
        shot(OSPT_IDX_OSCTRL, 8'h01);
        wait_pulse();
        chkw("next width", 6, width);
        q0 = pin_irqs;
        for (int i = 0; i < 6; i++) begin
            set_io(pio[i]);
            p0 = pulses;
            u_pin.set_pin(plv[i]);
            repeat (30) @(posedge clk);
            chkw("pin trigger", p0 + pexp[i], pulses);
        end
        chkw("pin irq edges", q0 + 3, pin_irqs);
        restart(2'h0, 2'h0);
        set_io(8'h02);
        chk("latch output", latch, pulse);
        set_io(8'h01);
        chk("idle level inverted", 1'h1, pulse);
        restart(2'h0, OSPT_MODE_WAIT);
        bus(1'h1, OSPT_IDX_SECOND, 8'h07);
        shot(OSPT_IDX_OSCTRL, 8'h01);
        wait_pulse();
        chkw("wait pulse width", 8, width);
        chk("wait length", 1'h1, start - t0 >= 8 && start - t0 <= 14);
        bus(1'h0, OSPT_IDX_PRIMARY, 8'h00);
        chk("primary after wait", 8'h05, rv);
        bus(1'h0, OSPT_IDX_OSCTRL, 8'h00);
        chk("active cleared", 1'h0, rv[OSPT_OS_ACTIVE_BIT]);
        set_io(8'h00);
        restart(2'h0, OSPT_MODE_ONESHOT);
        bus(1'h1, OSPT_IDX_PRIMARY, 8'h3f);
        for (int i = 0; i < 3; i++) begin
            shot(OSPT_IDX_OSCTRL, 8'h01);
            repeat (10) @(posedge clk);
            bus(1'h1, sidx[i], sval[i]);
            wait_pulse();
            chk("stopped early", 1'h1, width < 30);
            bus(1'h0, OSPT_IDX_PRIMARY, 8'h00);
            chk("reload on stop", 8'h3f, rv);
            restart(2'h0, OSPT_MODE_ONESHOT);
        end
        test_done();
    end
endmodule
